// >>> rtl/rsi_target.sv
/*
 * Target end: address match, index register, byte store and read-out.
 * Assumes SCL and SDA arrive asynchronously; each is synchronised and
 * a change counts once the second and third flops agree.
 */
`timescale 1ns/1ps
module rsi_target #(
    parameter int NREG = 256
) (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    rsi_if.dev              bus,
    output logic            wr_stb_out,
    output logic [7:0]      wr_idx_out,
    output logic [7:0]      wr_data_out,
    output logic            busy_out
);
    // Refuse array sizes that an 8-bit index cannot serve
    if (NREG < 1 || NREG > 256) begin : g_bad_nreg
        $error("NREG out of range");
    end

    typedef enum logic [4:0] {
        RSI_IDLE = 5'b00001,
        RSI_RX   = 5'b00010,
        RSI_ACK  = 5'b00100,
        RSI_TX   = 5'b01000,
        RSI_MACK = 5'b10000
    } rsi_st_e;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic       scl_f;
        logic       sda_f;
        rsi_st_e    st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       rd;
        logic       addr_ph;
        logic       idx_ph;
        logic [7:0] idx;
        logic       oe;
        logic       stb;
        logic [7:0] widx;
        logic [7:0] wdat;
        logic       busy;
        logic       drop;
    } rsi_tgt_s;

    rsi_tgt_s r;
    rsi_tgt_s next_r;
    logic [7:0] mem [NREG];

    function automatic logic [7:0] rsi_wrap(input logic [7:0] i);
        rsi_wrap = (int'(i) >= NREG) ? 8'h00 : i;
    endfunction : rsi_wrap

    // Next state of the whole target
    always_comb begin
        logic sc;
        logic sd;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        next_r = r;
        next_r.scl_s = {r.scl_s[1:0], bus.scl};
        next_r.sda_s = {r.sda_s[1:0], bus.sda};
        sc = r.scl_f;
        sd = r.sda_f;
        if (r.scl_s[1] == r.scl_s[2]) next_r.scl_f = r.scl_s[2];
        if (r.sda_s[1] == r.sda_s[2]) next_r.sda_f = r.sda_s[2];
        rise  = ~sc & next_r.scl_f;
        fall  = sc & ~next_r.scl_f;
        start = sc & next_r.scl_f & sd & ~next_r.sda_f;
        stop  = sc & next_r.scl_f & ~sd & next_r.sda_f;
        next_r.stb = 1'b0;
        if (start) begin
            next_r.st      = RSI_RX;
            next_r.cnt     = 4'h0;
            next_r.addr_ph = 1'b1;
            next_r.oe      = 1'b0;
            next_r.drop    = 1'b0;
        end else if (stop) begin
            next_r.st = RSI_IDLE;
            next_r.oe = 1'b0;
        end else begin
            unique case (r.st)
                RSI_IDLE: begin
                    next_r.oe = 1'b0;
                end
                RSI_RX: begin
                    if (rise) begin
                        next_r.sh  = {r.sh[6:0], next_r.sda_f};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    if (fall && r.cnt == rsi_pkg::BITS) begin
                        next_r.cnt = 4'h0;
                        if (r.addr_ph) begin
                            if (r.sh[7:1] == rsi_pkg::ADDR_WR[7:1]) begin
                                next_r.rd      = r.sh[0];
                                next_r.idx_ph  = ~r.sh[0];
                                next_r.addr_ph = 1'b0;
                                next_r.oe      = 1'b1;
                                next_r.st      = RSI_ACK;
                            end else begin
                                next_r.st = RSI_IDLE;
                            end
                        end else begin
                            next_r.oe = 1'b1;
                            next_r.st = RSI_ACK;
                            if (r.idx_ph) begin
                                next_r.idx    = r.sh;
                                next_r.idx_ph = 1'b0;
                            end else begin
                                next_r.stb  = 1'b1;
                                next_r.widx = r.idx;
                                next_r.wdat = r.sh;
                                next_r.idx  = rsi_wrap(r.idx + 8'h01);
                            end
                        end
                    end
                end
                RSI_ACK: begin
                    if (fall) begin
                        if (r.rd) begin
                            next_r.sh  = mem[r.idx];
                            next_r.oe  = ~mem[r.idx][7];
                            next_r.cnt = 4'h1;
                            next_r.idx = rsi_wrap(r.idx + 8'h01);
                            next_r.st  = RSI_TX;
                        end else begin
                            next_r.oe = 1'b0;
                            next_r.st = RSI_RX;
                        end
                    end
                end
                RSI_TX: begin
                    if (fall) begin
                        if (r.cnt == rsi_pkg::BITS) begin
                            next_r.oe = 1'b0;
                            next_r.st = RSI_MACK;
                        end else begin
                            next_r.sh  = {r.sh[6:0], 1'b0};
                            next_r.oe  = ~r.sh[6];
                            next_r.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                RSI_MACK: begin
                    if (rise) next_r.drop = next_r.sda_f;
                    if (fall) begin
                        if (r.drop) begin
                            next_r.st = RSI_IDLE;
                        end else begin
                            next_r.sh  = mem[r.idx];
                            next_r.oe  = ~mem[r.idx][7];
                            next_r.cnt = 4'h1;
                            next_r.idx = rsi_wrap(r.idx + 8'h01);
                            next_r.st  = RSI_TX;
                        end
                    end
                end
                default: next_r.st = RSI_IDLE;
            endcase
        end
        next_r.busy = (next_r.st != RSI_IDLE);
    end

    // State register
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r         <= '0;
            r.scl_s   <= 3'h7;
            r.sda_s   <= 3'h7;
            r.scl_f   <= 1'b1;
            r.sda_f   <= 1'b1;
            r.st      <= RSI_IDLE;
            r.idx     <= rsi_pkg::IDX_RST;
        end else begin
            r <= next_r;
        end
    end

    // Register array written by the bus
    always_ff @(posedge mclk_in) begin
        if (r.stb) mem[r.widx] <= r.wdat;
    end

    assign bus.sda_out_oe_dev = r.oe;
    assign wr_stb_out  = r.stb;
    assign wr_idx_out  = r.widx;
    assign wr_data_out = r.wdat;
    assign busy_out    = r.busy;
endmodule : rsi_target

// >>> rtl/rsi_pkg.sv
/*
 * Constants shared by both ends of the serial target link.
 * Assumes a 200 MHz system clock on each end and open-drain wiring
 * resolved by the interface.
 */
// What this block does
// - Answer only address byte 0x52 form
// - Address lsb picks write or read
// - Eight bits then one acknowledge slot
// - Sample on rising clock; start/stop exceptions
// - Start, bytes, then stop or restart
// - Host opens each message with start
// - Acknowledge own address, keep direction bit
// - First written byte is register index
// - Shift in, acknowledge, store at index
// - Read loads indexed register after address
// - Read data changes on falling clock
// - Receiver acknowledges every byte; the host naks its one read byte
// - Only host ends a message
// - Index increments after each data byte
// - Host may stream bytes without index
// - Lines only pulled low, idle high
// - Host makes clock, starts transfers
// - Multibyte: ascending index, MSB first
package rsi_pkg;
    localparam logic [6:0] ADDR7      = 7'h29;
    localparam logic [7:0] ADDR_WR    = 8'h52;
    localparam logic [7:0] ADDR_RD    = 8'h53;
    localparam logic [7:0] IDX_RST    = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [3:0] BITS       = 4'h8;
    localparam int         CLK_HZ     = 200_000_000;
    localparam int         SCL_HZ     = 400_000;
    // Quarter period of the generated clock, rounded down
    localparam int         QTR_CYC    = CLK_HZ / (SCL_HZ * 4);
    localparam logic [1:0] SYNC_RST   = 2'h3;
endpackage : rsi_pkg

// >>> rtl/rsi_if.sv
/*
 * Two-wire bus between host and target, with open-drain resolution.
 * Assumes external pull-ups: an undriven line reads high.
 */
`timescale 1ns/1ps
interface rsi_if;
    logic scl_out_oe_host;
    logic sda_out_oe_host;
    logic sda_out_oe_dev;
    logic scl;
    logic sda;

    // Wired-and of low drivers
    assign scl = ~scl_out_oe_host;
    assign sda = ~(sda_out_oe_host | sda_out_oe_dev);

    modport dev (
        input  scl,
        input  sda,
        output sda_out_oe_dev
    );
    modport host (
        input  scl,
        input  sda,
        output scl_out_oe_host,
        output sda_out_oe_host
    );
endinterface : rsi_if

// >>> rtl/rsi_host.sv
/*
 * Host end: makes the clock and runs one message per request.
 * Assumes the user holds request fields steady until done_out.
 */
`timescale 1ns/1ps
module rsi_host (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    rsi_if.host             bus,
    input  wire logic       req_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] idx_in,
    input  wire logic [7:0] wdata_in,
    output logic            done_out,
    output logic [7:0]      rdata_out,
    output logic            nak_out
);
    typedef enum logic [3:0] {
        RSH_IDLE = 4'b0001,
        RSH_STA  = 4'b0010,
        RSH_BIT  = 4'b0100,
        RSH_STO  = 4'b1000
    } rsh_st_e;

    typedef struct packed {
        rsh_st_e    st;
        logic [1:0] ph;
        logic [7:0] tmr;
        logic [1:0] byt;
        logic [3:0] bit_n;
        logic [7:0] sh;
        logic [7:0] rx;
        logic       restart;
        logic       scl_oe;
        logic       sda_oe;
        logic       done;
        logic       nak;
        logic [7:0] rdata;
        logic [2:0] sda_s;
        logic       sda_f;
    } rsh_s;

    rsh_s r;
    rsh_s next_r;
    localparam logic [7:0] QTR = 8'(rsi_pkg::QTR_CYC - 1);

    // Host sequencing: one quarter of the bit period per phase
    always_comb begin
        logic tick;
        next_r = r;
        next_r.done = 1'b0;
        tick = (r.tmr == 8'h00);
        // Data line from the far end: three flops, second and third agree
        next_r.sda_s = {r.sda_s[1:0], bus.sda};
        if (r.sda_s[1] == r.sda_s[2]) next_r.sda_f = r.sda_s[2];
        next_r.tmr = tick ? QTR : r.tmr - 8'h01;
        unique case (r.st)
            RSH_IDLE: begin
                next_r.scl_oe = 1'b0;
                next_r.sda_oe = 1'b0;
                if (req_in) begin
                    next_r.st      = RSH_STA;
                    next_r.ph      = 2'h0;
                    next_r.byt     = 2'h0;
                    next_r.restart = 1'b0;
                    next_r.nak     = 1'b0;
                end
            end
            RSH_STA: if (tick) begin
                next_r.ph = r.ph + 2'h1;
                unique case (r.ph)
                    2'h0: begin next_r.sda_oe = 1'b0; end
                    2'h1: begin next_r.scl_oe = 1'b0; end
                    2'h2: begin next_r.sda_oe = 1'b1; end
                    default: begin
                        next_r.scl_oe = 1'b1;
                        next_r.bit_n  = 4'h0;
                        next_r.sh = (r.restart) ? rsi_pkg::ADDR_RD
                                                : rsi_pkg::ADDR_WR;
                        next_r.st = RSH_BIT;
                    end
                endcase
            end
            RSH_BIT: if (tick) begin
                next_r.ph = r.ph + 2'h1;
                unique case (r.ph)
                    2'h0: begin
                        // Released: target acks, or host naks its one read
                        if (r.bit_n == rsi_pkg::BITS)
                            next_r.sda_oe = 1'b0;
                        else
                            next_r.sda_oe = r.restart && r.byt != 2'h0
                                ? 1'b0 : ~r.sh[7];
                    end
                    2'h1: next_r.scl_oe = 1'b0;
                    2'h2: begin
                        if (r.bit_n == rsi_pkg::BITS) next_r.nak = r.sda_f
                            & ~(r.restart && r.byt != 2'h0);
                        else next_r.rx = {r.rx[6:0], r.sda_f};
                    end
                    default: begin
                        next_r.scl_oe = 1'b1;
                        if (r.bit_n == rsi_pkg::BITS) begin
                            next_r.bit_n = 4'h0;
                            next_r.byt   = r.byt + 2'h1;
                            if (r.restart && r.byt != 2'h0) begin
                                next_r.rdata = r.rx;
                                next_r.st    = RSH_STO;
                            end else if (r.nak) begin
                                next_r.st = RSH_STO;
                            end else if (r.byt == 2'h1 && rd_in
                                         && !r.restart) begin
                                next_r.restart = 1'b1;
                                next_r.byt     = 2'h0;
                                next_r.sda_oe  = 1'b0;
                                next_r.st      = RSH_STA;
                            end else if (r.byt == 2'h2) begin
                                next_r.st = RSH_STO;
                            end else if (r.restart) begin
                                next_r.sh = 8'hFF;
                            end else begin
                                next_r.sh = (r.byt == 2'h0) ? idx_in
                                                            : wdata_in;
                            end
                        end else begin
                            next_r.sh    = {r.sh[6:0], 1'b0};
                            next_r.bit_n = r.bit_n + 4'h1;
                        end
                    end
                endcase
            end
            RSH_STO: if (tick) begin
                next_r.ph = r.ph + 2'h1;
                unique case (r.ph)
                    2'h0: next_r.sda_oe = 1'b1;
                    2'h1: next_r.scl_oe = 1'b0;
                    2'h2: next_r.sda_oe = 1'b0;
                    default: begin
                        next_r.done = 1'b1;
                        next_r.st   = RSH_IDLE;
                    end
                endcase
            end
            default: next_r.st = RSH_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r       <= '0;
            r.st    <= RSH_IDLE;
            r.sda_s <= 3'h7;
            r.sda_f <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.scl_out_oe_host = r.scl_oe;
    assign bus.sda_out_oe_host = r.sda_oe;
    assign done_out  = r.done;
    assign rdata_out = r.rdata;
    assign nak_out   = r.nak;
endmodule : rsi_host

// >>> bench/rsi_chk.sv
/* Concurrent checks on the wire between the host and target ends.
   Assumes one mclk_in domain and lines already resolved by rsi_if. */
`timescale 1ns/1ps
module rsi_chk (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_out_oe_host,
    input wire logic sda_out_oe_host,
    input wire logic sda_out_oe_dev
);
    logic       scl_q;
    logic       sda_q;
    logic       first;
    logic       rd;
    logic       idle;
    logic [3:0] nbit;
    logic [7:0] shreg;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    // Tracks start, stop, bit slots and the address byte
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {scl_q, sda_q, first, rd, idle, nbit, shreg} <= {5'h19, 12'h000};
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                {nbit, first, rd, idle} <= 7'h04;
            end else if (scl && scl_q && !sda_q && sda) begin
                idle <= 1'b1;
            end else if (scl && !scl_q) begin
                nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
                if (nbit != 4'h8) shreg <= {shreg[6:0], sda};
                if (nbit == 4'h8) first <= 1'b0;
                if (nbit == 4'h8 && first) rd <= shreg[0];
            end
        end
    end

    a_own_addr_ack: assert property (scl && !scl_q && nbit == 4'h8 && first
        && shreg[7:1] == rsi_pkg::ADDR7 |-> !sda) else $error("no address ack");
    a_ack_in_time: assert property ($fell(scl) && nbit == 4'h8 && first
        && shreg[7:1] == rsi_pkg::ADDR7 |-> ##[1:8] sda_out_oe_dev)
        else $error("address ack late");
    a_dev_change_low: assert property ($changed(sda_out_oe_dev)
        |-> !scl && !$past(scl, 2)) else $error("target moved sda with scl high");
    a_ack_one_slot: assert property ($fell(scl) && nbit == 4'h0 && !first
        && !rd |-> ##[1:8] !sda_out_oe_dev) else $error("ack held too long");
    a_host_ack_free: assert property ($fell(scl) && rd && !first
        && nbit == 4'h8 |-> ##[1:8] (!sda_out_oe_dev [*8]))
        else $error("target blocks host ack");
    a_idle_no_drive: assert property (idle |-> !sda_out_oe_dev)
        else $error("target drives idle bus");
    a_sda_high_event: assert property (scl && $past(scl) && $changed(sda)
        |=> (nbit == 4'h0 && first) || idle) else $error("sda moved in high");
    a_dev_quiet_write: assert property (scl && nbit != 4'h8 && nbit != 4'h0
        && (!rd || first) |-> !sda_out_oe_dev) else $error("target drove data");
endmodule : rsi_chk

// >>> bench/ranging_sensor_i2c_target_test.sv
/* Self-checking bench: host and target ends on one bus, and a second
   target driven bit by bit for streaming and faulty traffic.
   Assumes the rsi_pkg constants and a 200 MHz system clock. */
`timescale 1ns/1ps
module ranging_sensor_i2c_target_test;
    localparam int NREG = 256;
    logic        mclk;
    logic        resetn;
    logic        req;
    logic        rd;
    logic [7:0]  idx;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;
    logic        nak;
    logic        stb1;
    logic [7:0]  widx1;
    logic [7:0]  wdat1;
    logic        stb2;
    logic [7:0]  widx2;
    logic [7:0]  wdat2;
    logic        busy2;
    logic [31:0] seed;
    logic [15:0] log2[$];
    int          n_stb1;
    int          n_mismatch;
    int          check_count;
    int          ncyc;

    rsi_if b1();
    rsi_if b2();
    rsi_host i_rsi_host (.mclk_in(mclk), .resetn_in(resetn), .bus(b1),
        .req_in(req), .rd_in(rd), .idx_in(idx), .wdata_in(wdata),
        .done_out(done), .rdata_out(rdata), .nak_out(nak));
    rsi_target #(.NREG(NREG)) i_rsi_target (.mclk_in(mclk),
        .resetn_in(resetn), .bus(b1), .wr_stb_out(stb1),
        .wr_idx_out(widx1), .wr_data_out(wdat1), .busy_out());
    rsi_target #(.NREG(NREG)) i_rsi_target_2 (.mclk_in(mclk),
        .resetn_in(resetn), .bus(b2), .wr_stb_out(stb2),
        .wr_idx_out(widx2), .wr_data_out(wdat2), .busy_out(busy2));
    rsi_chk i_rsi_chk (.mclk_in(mclk), .resetn_in(resetn), .scl(b1.scl),
        .sda(b1.sda), .scl_out_oe_host(b1.scl_out_oe_host),
        .sda_out_oe_host(b1.sda_out_oe_host),
        .sda_out_oe_dev(b1.sda_out_oe_dev));

    // System clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Cycle ceiling and store logs
    always @(posedge mclk) begin
        ncyc++;
        if (stb1 === 1'b1) n_stb1++;
        if (stb2 === 1'b1) log2.push_back({widx2, wdat2});
        if (ncyc == 100000) begin
            n_mismatch++;
            stop_test();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Index after k auto-increments, wrapping past NREG
    function automatic logic [7:0] nxt_idx(input logic [7:0] b, input int k);
        return 8'((int'(b) + k) % NREG);
    endfunction : nxt_idx

    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_byte(nm, {7'h00, e}, {7'h00, g});
    endtask : chk_bit
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // One bit slot on the second bus, 125 ns, sampled mid-high
    task automatic bit2(input logic b, output logic s);
        b2.sda_out_oe_host = ~b;
        cyc(7);
        b2.scl_out_oe_host = 1'b0;
        cyc(6);
        s = b2.sda;
        cyc(6);
        b2.scl_out_oe_host = 1'b1;
        cyc(6);
    endtask : bit2
    task automatic start2();
        b2.sda_out_oe_host = 1'b0;
        cyc(6);
        b2.scl_out_oe_host = 1'b0;
        cyc(6);
        b2.sda_out_oe_host = 1'b1;
        cyc(6);
        b2.scl_out_oe_host = 1'b1;
        cyc(6);
    endtask : start2
    task automatic stop2();
        b2.sda_out_oe_host = 1'b1;
        cyc(6);
        b2.scl_out_oe_host = 1'b0;
        cyc(6);
        b2.sda_out_oe_host = 1'b0;
        cyc(12);
    endtask : stop2
    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic hack,
                        output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--) bit2(tx[i], rx[i]);
        bit2(hack, ak);
    endtask : xfer
    task automatic host_op(input logic r, input logic [7:0] i,
                           input logic [7:0] d);
        int t;
        {rd, idx, wdata, req} = {r, i, d, 1'b1};
        t = 0;
        do begin
            cyc(1);
            t++;
        end while (done !== 1'b1 && t < 30000);
        req = 1'b0;
        cyc(1);
        if (t == 30000) begin
            n_mismatch++;
            stop_test();
        end
    endtask : host_op

    // Main sequence
    initial begin
        logic [7:0] i0;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] sd[3];
        logic [7:0] rx;
        logic       ak;
        {resetn, req, rd, idx, wdata} = 19'h00000;
        b2.scl_out_oe_host = 1'b0;
        b2.sda_out_oe_host = 1'b0;
        seed = xs(32'hE1F4);
        {d1, d0, i0} = {seed[23:8], 1'b0, seed[6:0]};
        cyc(6);
        resetn = 1'b1;
        host_op(1'b0, i0, d0);
        chk_byte("store_idx", i0, widx1);
        chk_byte("store_data", d0, wdat1);
        chk_bit("write_nak", 1'b0, nak);
        host_op(1'b0, 8'hFF, d1);
        chk_byte("store_idx", 8'hFF, widx1);
        host_op(1'b1, i0, 8'h00);
        chk_byte("read_data", d0, rdata);
        host_op(1'b1, 8'hFF, 8'h00);
        chk_byte("read_data", d1, rdata);
        chk_byte("store_count", 8'h02, 8'(n_stb1));
        // Faulty traffic on the second bus
        b2.scl_out_oe_host = 1'b1;
        cyc(6);
        xfer(rsi_pkg::ADDR_WR, 1'b1, rx, ak);
        chk_bit("nostart_ack", 1'b1, ak);
        stop2();
        start2();
        xfer(8'hA4, 1'b1, rx, ak);
        chk_bit("foreign_ack", 1'b1, ak);
        chk_bit("reject_busy", 1'b0, busy2);
        stop2();
        // Streamed write across the index wrap
        start2();
        xfer(rsi_pkg::ADDR_WR, 1'b1, rx, ak);
        chk_bit("addr_ack", 1'b0, ak);
        chk_bit("msg_busy", 1'b1, busy2);
        xfer(8'hFE, 1'b1, rx, ak);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            sd[k] = seed[7:0];
            xfer(sd[k], 1'b1, rx, ak);
            chk_bit("data_ack", 1'b0, ak);
        end
        stop2();
        chk_byte("stream_count", 8'h03, 8'(log2.size()));
        for (int k = 0; k < 3; k++) begin
            chk_byte("stream_idx", nxt_idx(8'hFE, k), log2[k][15:8]);
            chk_byte("stream_data", sd[k], log2[k][7:0]);
        end
        // Streamed read after a repeated start
        start2();
        xfer(rsi_pkg::ADDR_WR, 1'b1, rx, ak);
        xfer(8'hFE, 1'b1, rx, ak);
        start2();
        xfer(rsi_pkg::ADDR_RD, 1'b1, rx, ak);
        chk_bit("read_addr_ack", 1'b0, ak);
        for (int k = 0; k < 3; k++) begin
            xfer(8'hFF, k == 2, rx, ak);
            chk_byte("stream_read", sd[k], rx);
        end
        stop2();
        stop_test();
    end
endmodule : ranging_sensor_i2c_target_test
